// file: hdl/print_engine_sequencer.v
`timescale 1ns/1ps
`include "pes_defines.vh"

// Overview of operation
// - Stay in warm-up until fuser and rollers are hot; expect under four minutes.
// - Warm-up runs fans 1-6 for 30 s, duplex fan for 3 s.
// - Warm-up starts formatter link, heaters, cartridge check and toner memory read.
// - Warm-up opens each accessory link before leaving warm-up.
// - Warm-up exit needs cassette, jam, wrap jam, door and sleep checks clean.
// - Idle hold targets fuser 180 C and pressure roller 140 C.
// - Idle hold waits for the formatter reservation, then enters spin-up.
// - Idle hold runs fans 1-5 at half speed, fan 6 off.
// - After five idle minutes pulse fuser motor about 0.08 s.
// - Spin-up starts on reservation and lasts until scanner reports ready.
// - Spin-up runs scanner, fuser and drum motors; negative transfer bias.
// - Spin-up runs fans 1-6 full and starts paper pickup.
// - Spin-up targets 190 C and 180 C, enables charge, develop, transfer bias.
// - Spin-up completes only with high voltage, scanner speed and pickup done.
// - Spin-up stops the sequence on jam, door, failure or sleep.
// - Print starts on print command, ends when charging bias switches off.
// - Print exchanges engine-to-formatter and formatter-to-engine timing signals.
// - Print runs next-pickup speed control while watching jam, door, failure.
// - Spin-down starts at charging bias off, lasts until all motors stop.
// - Spin-down returns fuser to 180 C with fans 1-6 full.
// - Spin-down stops motors and writes cartridge memory.
module print_engine_sequencer #(
    parameter TICK_CYCLES = `TICK_CYCLES
) (
    input  wire        clock_in,
    input  wire        arst_n_in,
    input  wire [3:0]  avs_address_in,
    input  wire        avs_read_in,
    input  wire        avs_write_in,
    input  wire [31:0] avs_writedata_in,
    input  wire [3:0]  avs_byteenable_in,
    output reg  [31:0] avs_readdata_out,
    output reg         avs_waitrequest_out,
    input  wire        temps_ready_in,
    input  wire        cart_present_in,
    input  wire        toner_read_done_in,
    input  wire [2:0]  accessory_ack_in,
    input  wire        cassette_ok_in,
    input  wire        jam_in,
    input  wire        wrap_jam_in,
    input  wire        door_open_in,
    input  wire        sleep_in,
    input  wire        failure_in,
    input  wire        reserve_cmd_in,
    input  wire        print_cmd_in,
    input  wire        fmt_to_eng_in,
    input  wire        scanner_ready_in,
    input  wire        hv_present_in,
    input  wire        scanner_at_speed_in,
    input  wire        pickup_done_in,
    input  wire        motors_stopped_in,
    output reg  [2:0]  phase_out,
    output reg  [5:0]  fan_on_out,
    output reg         fan_half_out,
    output reg         fan_duplex_out,
    output reg         heater_on_out,
    output reg  [7:0]  fuser_target_out,
    output reg  [7:0]  press_target_out,
    output reg         fmt_link_en_out,
    output reg         cart_check_out,
    output reg         toner_read_out,
    output reg  [2:0]  accessory_open_out,
    output reg         fuser_motor_out,
    output reg         drum_motor_out,
    output reg         scanner_motor_out,
    output reg         bias_charge_out,
    output reg         bias_develop_out,
    output reg         bias_transfer_out,
    output reg         transfer_neg_out,
    output reg         pickup_start_out,
    output reg         eng_to_fmt_out,
    output reg         next_pickup_out,
    output reg  [7:0]  speed_out,
    output reg         cart_write_out
);

    // Phases
    localparam [2:0] WARM_UP         = 3'h0;
    localparam [2:0] IDLE_HOLD_PHASE = 3'h1;
    localparam [2:0] SPIN_UP_PHASE   = 3'h2;
    localparam [2:0] PRINT_PHASE     = 3'h3;
    localparam [2:0] SPIN_DOWN_PHASE = 3'h4;

    localparam [15:0] WARM_LIMIT = `WARM_LIMIT_T;
    localparam [15:0] FAN_RUN    = `FAN_RUN_T;
    localparam [15:0] DUPFAN_RUN = `DUPFAN_RUN_T;
    localparam [15:0] IDLE_NUDGE = `IDLE_NUDGE_T;
    localparam [15:0] NUDGE_LEN  = `NUDGE_T;

    reg  [2:0]  phase_r;
    reg  [2:0]  phase_nxt;
    reg  [15:0] ticks_r;
    reg  [15:0] nudge_r;
    reg         nudging_r;
    reg         run_en_r;
    reg  [7:0]  speed_r;
    reg  [15:0] pages_r;
    reg         fmt_prev_r;
    reg         timeout_r;
    reg         jam_flag_r;
    reg         door_flag_r;
    reg         fail_flag_r;
    reg         sleep_flag_r;
    wire        tick;
    wire        fmt_rise;
    wire        watch;
    wire        warm_checks_ok;
    wire        bus_req;
    wire        bus_done;
    wire        wr_done;
    wire        fault_clr;

    slow_tick #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clock_in  (clock_in),
        .arst_n_in (arst_n_in),
        .tick_out  (tick)
    );

    assign fmt_rise = fmt_to_eng_in & ~fmt_prev_r;

    assign warm_checks_ok = cart_present_in & toner_read_done_in &
                            (&accessory_ack_in) & cassette_ok_in &
                            ~jam_in & ~wrap_jam_in & ~door_open_in & ~sleep_in;

    assign watch = jam_in | door_open_in | failure_in |
                   (sleep_in & (phase_r == SPIN_UP_PHASE));

    // Bus handshake: request held until waitrequest sampled low
    assign bus_req   = avs_read_in | avs_write_in;
    assign bus_done  = bus_req & ~avs_waitrequest_out;
    assign wr_done   = bus_done & avs_write_in;
    assign fault_clr = wr_done & (avs_address_in == `REG_CTRL) &
                       avs_byteenable_in[0] & avs_writedata_in[`CTRL_FCLR];

    // Next phase decode
    always @* begin
        phase_nxt = phase_r;
        case (phase_r)
            WARM_UP: begin
                // leave only when hot and checks pass
                if (temps_ready_in && warm_checks_ok)
                    phase_nxt = IDLE_HOLD_PHASE;
            end
            IDLE_HOLD_PHASE: begin
                if (run_en_r && reserve_cmd_in && !watch)
                    phase_nxt = SPIN_UP_PHASE;
            end
            SPIN_UP_PHASE: begin
                if (watch)
                    phase_nxt = SPIN_DOWN_PHASE;
                else if (scanner_ready_in && hv_present_in && scanner_at_speed_in &&
                         pickup_done_in && print_cmd_in)
                    phase_nxt = PRINT_PHASE;
            end
            PRINT_PHASE: begin
                if (watch || !print_cmd_in)
                    phase_nxt = SPIN_DOWN_PHASE;
            end
            SPIN_DOWN_PHASE: begin
                if (motors_stopped_in)
                    phase_nxt = IDLE_HOLD_PHASE;
            end
            default: phase_nxt = WARM_UP;
        endcase
    end

    // Phase register and phase-relative tick counter
    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            phase_r <= WARM_UP;
            ticks_r <= 16'h0000;
        end else begin
            phase_r <= phase_nxt;
            if (phase_nxt != phase_r)
                ticks_r <= 16'h0000;
            else if (tick && ticks_r != 16'hffff)
                ticks_r <= ticks_r + 16'h0001;
        end
    end

    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            nudge_r   <= 16'h0000;
            nudging_r <= 1'b0;
        end else if (phase_r != IDLE_HOLD_PHASE) begin
            nudge_r   <= 16'h0000;
            nudging_r <= 1'b0;
        end else if (tick) begin
            if (nudging_r && nudge_r >= NUDGE_LEN - 16'h0001) begin
                nudge_r   <= 16'h0000;
                nudging_r <= 1'b0;
            end else if (!nudging_r && nudge_r >= IDLE_NUDGE - 16'h0001) begin
                nudge_r   <= 16'h0000;
                nudging_r <= 1'b1;
            end else begin
                nudge_r   <= nudge_r + 16'h0001;
            end
        end
    end

    // Warm-up overrun and sticky fault flags, set wins over clear
    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            timeout_r    <= 1'b0;
            jam_flag_r   <= 1'b0;
            door_flag_r  <= 1'b0;
            fail_flag_r  <= 1'b0;
            sleep_flag_r <= 1'b0;
        end else begin
            timeout_r    <= (phase_r == WARM_UP && ticks_r >= WARM_LIMIT) |
                            (timeout_r & ~fault_clr);
            jam_flag_r   <= (jam_in | wrap_jam_in) | (jam_flag_r & ~fault_clr);
            door_flag_r  <= door_open_in | (door_flag_r & ~fault_clr);
            fail_flag_r  <= failure_in | (fail_flag_r & ~fault_clr);
            sleep_flag_r <= sleep_in | (sleep_flag_r & ~fault_clr);
        end
    end

    // Formatter page strobe and next-pickup control
    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            fmt_prev_r      <= 1'b0;
            pages_r         <= 16'h0000;
            next_pickup_out <= 1'b0;
            speed_out       <= `SPEED_RST;
        end else begin
            fmt_prev_r      <= fmt_to_eng_in;
            next_pickup_out <= 1'b0;
            // each page edge schedules next sheet speed
            if (phase_r == PRINT_PHASE && fmt_rise && !watch) begin
                pages_r         <= pages_r + 16'h0001;
                next_pickup_out <= 1'b1;
                speed_out       <= speed_r;
            end
        end
    end

    // Registered phase outputs
    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            phase_out          <= WARM_UP;
            fan_on_out         <= 6'h00;
            fan_half_out       <= 1'b0;
            fan_duplex_out     <= 1'b0;
            heater_on_out      <= 1'b0;
            fuser_target_out   <= `T_FUSER_IDLE;
            press_target_out   <= `T_PRESS_IDLE;
            fmt_link_en_out    <= 1'b0;
            cart_check_out     <= 1'b0;
            toner_read_out     <= 1'b0;
            accessory_open_out <= 3'h0;
            fuser_motor_out    <= 1'b0;
            drum_motor_out     <= 1'b0;
            scanner_motor_out  <= 1'b0;
            bias_charge_out    <= 1'b0;
            bias_develop_out   <= 1'b0;
            bias_transfer_out  <= 1'b0;
            transfer_neg_out   <= 1'b0;
            pickup_start_out   <= 1'b0;
            eng_to_fmt_out     <= 1'b0;
            cart_write_out     <= 1'b0;
        end else begin
            phase_out          <= phase_r;
            // Link and heaters stay up once started
            heater_on_out      <= 1'b1;
            fmt_link_en_out    <= 1'b1;
            accessory_open_out <= 3'h7;
            fan_on_out         <= 6'h3f;
            fan_half_out       <= 1'b0;
            fan_duplex_out     <= 1'b0;
            fuser_target_out   <= `T_FUSER_IDLE;
            press_target_out   <= `T_PRESS_IDLE;
            cart_check_out     <= 1'b0;
            toner_read_out     <= 1'b0;
            fuser_motor_out    <= 1'b0;
            drum_motor_out     <= 1'b0;
            scanner_motor_out  <= 1'b0;
            bias_charge_out    <= 1'b0;
            bias_develop_out   <= 1'b0;
            bias_transfer_out  <= 1'b0;
            transfer_neg_out   <= 1'b0;
            pickup_start_out   <= 1'b0;
            eng_to_fmt_out     <= 1'b0;
            cart_write_out     <= 1'b0;
            case (phase_r)
                WARM_UP: begin
                    fan_on_out     <= (ticks_r < FAN_RUN) ? 6'h3f : 6'h00;
                    fan_duplex_out <= (ticks_r < DUPFAN_RUN);
                    cart_check_out <= ~cart_present_in;
                    toner_read_out <= ~toner_read_done_in;
                    // accessory links held open whatever the acks say
                    accessory_open_out <= 3'h7;
                end
                IDLE_HOLD_PHASE: begin
                    // idle targets come from defaults above
                    // half speed fans, fan six off
                    fan_on_out      <= 6'h1f;
                    fan_half_out    <= 1'b1;
                    fuser_motor_out <= nudging_r;
                end
                SPIN_UP_PHASE: begin
                    scanner_motor_out <= 1'b1;
                    fuser_motor_out   <= 1'b1;
                    drum_motor_out    <= 1'b1;
                    transfer_neg_out  <= 1'b1;
                    pickup_start_out  <= ~pickup_done_in;
                    fuser_target_out  <= `T_FUSER_PRINT;
                    press_target_out  <= `T_PRESS_PRINT;
                    bias_charge_out   <= 1'b1;
                    bias_develop_out  <= 1'b1;
                    bias_transfer_out <= 1'b1;
                end
                PRINT_PHASE: begin
                    scanner_motor_out <= 1'b1;
                    fuser_motor_out   <= 1'b1;
                    drum_motor_out    <= 1'b1;
                    fuser_target_out  <= `T_FUSER_PRINT;
                    press_target_out  <= `T_PRESS_PRINT;
                    bias_charge_out   <= print_cmd_in;
                    bias_develop_out  <= 1'b1;
                    bias_transfer_out <= 1'b1;
                    eng_to_fmt_out    <= pickup_done_in;
                end
                SPIN_DOWN_PHASE: begin
                    fan_on_out     <= 6'h3f;
                    // motors off, cartridge write while stopping
                    cart_write_out <= ~motors_stopped_in;
                end
                default: begin
                    fan_on_out <= 6'h3f;
                end
            endcase
        end
    end

    // Avalon slave: one wait state, then completion
    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out    <= 32'h00000000;
            run_en_r            <= `CTRL_RST;
            speed_r             <= `SPEED_RST;
        end else begin
            avs_waitrequest_out <= ~(bus_req & avs_waitrequest_out);
            if (bus_req && avs_waitrequest_out) begin
                case (avs_address_in)
                    `REG_CTRL:   avs_readdata_out <= {31'h00000000, run_en_r};
                    `REG_STATUS: avs_readdata_out <= {24'h000000, sleep_flag_r,
                                                      fail_flag_r, door_flag_r,
                                                      jam_flag_r, timeout_r, phase_r};
                    `REG_SPEED:  avs_readdata_out <= {24'h000000, speed_r};
                    `REG_PAGES:  avs_readdata_out <= {16'h0000, pages_r};
                    default:     avs_readdata_out <= 32'h00000000;
                endcase
            end
            // Writes act at the completing edge
            if (wr_done && avs_byteenable_in[0]) begin
                if (avs_address_in == `REG_CTRL)
                    run_en_r <= avs_writedata_in[`CTRL_RUN];
                if (avs_address_in == `REG_SPEED)
                    speed_r <= avs_writedata_in[7:0];
            end
        end
    end

endmodule

// file: hdl/pes_defines.vh
`ifndef PES_DEFINES_VH
`define PES_DEFINES_VH

// Controller clock and slow tick
`define CLK_HZ          25000000
`define TICK_MS         10
`define TICK_CYCLES     (`CLK_HZ / 1000 * `TICK_MS)
`define TICKS_PER_S     (1000 / `TICK_MS)

// Phase durations in their own units
`define WARM_LIMIT_S    240
`define FAN_RUN_S       30
`define DUPFAN_RUN_S    3
`define IDLE_NUDGE_S    300
`define NUDGE_MS        80

// Durations as tick counts
`define WARM_LIMIT_T    (`WARM_LIMIT_S * `TICKS_PER_S)
`define FAN_RUN_T       (`FAN_RUN_S * `TICKS_PER_S)
`define DUPFAN_RUN_T    (`DUPFAN_RUN_S * `TICKS_PER_S)
`define IDLE_NUDGE_T    (`IDLE_NUDGE_S * `TICKS_PER_S)
`define NUDGE_T         (`NUDGE_MS / `TICK_MS)

// Temperature targets in degrees C
`define T_FUSER_IDLE    8'hb4
`define T_PRESS_IDLE    8'h8c
`define T_FUSER_PRINT   8'hbe
`define T_PRESS_PRINT   8'hb4

// Register byte offsets
`define REG_CTRL        4'h0
`define REG_STATUS      4'h4
`define REG_SPEED       4'h8
`define REG_PAGES       4'hc

// Field positions
`define CTRL_RUN        0
`define CTRL_FCLR       1
`define ST_TIMEOUT      3
`define ST_JAM          4
`define ST_DOOR         5
`define ST_FAIL         6
`define ST_SLEEP        7

// Reset values
`define CTRL_RST        1'b1
`define SPEED_RST       8'h80

`endif

// file: hdl/slow_tick.v
`timescale 1ns/1ps

module slow_tick #(
    parameter TICK_CYCLES = 250000
) (
    input  wire clock_in,
    input  wire arst_n_in,
    output reg  tick_out
);

    localparam [17:0] LAST = TICK_CYCLES - 1;

    reg [17:0] div_r;

    // Prescaler, one pulse per tick period
    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            div_r    <= 18'h00000;
            tick_out <= 1'b0;
        end else if (div_r == LAST) begin
            div_r    <= 18'h00000;
            tick_out <= 1'b1;
        end else begin
            div_r    <= div_r + 18'h00001;
            tick_out <= 1'b0;
        end
    end

endmodule

// file: verif/pes_checker_assertions.sv
`timescale 1ns/1ps
module pes_checker (
    input wire       clock_in,
    input wire       arst_n_in,
    input wire       reserve_cmd_in,
    input wire       print_cmd_in,
    input wire       fmt_to_eng_in,
    input wire       jam_in,
    input wire       door_open_in,
    input wire       failure_in,
    input wire       scanner_ready_in,
    input wire       hv_present_in,
    input wire       scanner_at_speed_in,
    input wire       pickup_done_in,
    input wire       motors_stopped_in,
    input wire [2:0] phase_out,
    input wire [5:0] fan_on_out,
    input wire       fan_half_out,
    input wire       heater_on_out,
    input wire [7:0] fuser_target_out,
    input wire [7:0] press_target_out,
    input wire       fmt_link_en_out,
    input wire [2:0] accessory_open_out,
    input wire       fuser_motor_out,
    input wire       drum_motor_out,
    input wire       scanner_motor_out,
    input wire       bias_charge_out,
    input wire       bias_develop_out,
    input wire       bias_transfer_out,
    input wire       transfer_neg_out,
    input wire       pickup_start_out,
    input wire       next_pickup_out,
    input wire       cart_write_out
);
    // All checks run on the controller clock and sleep through reset
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);
    warm_drive_a: assert property (phase_out == 3'd0 && $past(arst_n_in)
        |-> heater_on_out && fmt_link_en_out && accessory_open_out == 3'h7) else $error("Warm-up drive missing");
    idle_outputs_a: assert property (phase_out == 3'd1 |-> fan_on_out == 6'h1f && fan_half_out
        && fuser_target_out == 8'hb4 && press_target_out == 8'h8c) else $error("Idle outputs wrong");
    spin_entry_a: assert property (phase_out == 3'd2 && $past(phase_out) == 3'd1
        |-> $past(reserve_cmd_in, 2)) else $error("Spin-up without reservation");
    spin_motors_a: assert property (phase_out == 3'd2 |-> scanner_motor_out && fuser_motor_out && drum_motor_out
        && transfer_neg_out && bias_charge_out && bias_develop_out && bias_transfer_out) else $error("Spin-up drive wrong");
    spin_fans_a: assert property (phase_out == 3'd2 |-> fan_on_out == 6'h3f && press_target_out == 8'hb4
        && !fan_half_out && fuser_target_out == 8'hbe && (pickup_start_out || $past(pickup_done_in)))
        else $error("Spin-up fans or targets wrong");
    print_entry_a: assert property (phase_out == 3'd3 && $past(phase_out) == 3'd2 |-> $past(scanner_ready_in, 2)
        && $past(hv_present_in, 2) && $past(scanner_at_speed_in, 2) && $past(pickup_done_in, 2)) else $error("Early print");
    print_exit_a: assert property (phase_out == 3'd4 && $past(phase_out) == 3'd3 |-> !$past(print_cmd_in, 2)
        || $past(jam_in, 2) || $past(door_open_in, 2) || $past(failure_in, 2)) else $error("Print left without cause");
    fault_abort_a: assert property ((phase_out == 3'd2 || phase_out == 3'd3)
        && (jam_in || door_open_in || failure_in) |-> ##[1:2] phase_out == 3'd4) else $error("Fault not stopping run");
    down_drive_a: assert property (phase_out == 3'd4 |-> !fuser_motor_out && !drum_motor_out
        && !scanner_motor_out && (cart_write_out || $past(motors_stopped_in)) && fan_on_out == 6'h3f
        && fuser_target_out == 8'hb4) else $error("Spin-down drive wrong");
    page_pickup_a: assert property (phase_out == 3'd3 && print_cmd_in && $rose(fmt_to_eng_in)
        |-> ##[1:2] next_pickup_out) else $error("Page strobe without next pickup");
endmodule

bind print_engine_sequencer pes_checker u_chk (.*);

// file: verif/formatter_model.sv
`timescale 1ns/1ps
module formatter_model (
    input  wire       clock_in,
    input  wire       arst_n_in,
    input  wire       job_in,
    input  wire [2:0] phase_in,
    output reg        reserve_cmd_out,
    output reg        print_cmd_out,
    output reg        page_strobe_out
);
    reg [3:0] gap_r;
    reg [1:0] left_r;
    // One job: reserve in idle, hold print command, strobe two pages, then drop it
    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            reserve_cmd_out <= 1'b0;
            print_cmd_out <= 1'b0;
            page_strobe_out <= 1'b0;
            gap_r <= 4'h0;
            left_r <= 2'h0;
        end else begin
            gap_r <= gap_r + 4'h1;
            page_strobe_out <= 1'b0;
            reserve_cmd_out <= job_in && phase_in == 3'd1;
            if (phase_in == 3'd1)
                left_r <= 2'h2;
            if (phase_in == 3'd2)
                print_cmd_out <= 1'b1;
            if (phase_in == 3'd4)
                print_cmd_out <= 1'b0;
            if (phase_in == 3'd3 && gap_r == 4'hf) begin
                if (left_r != 2'h0) begin
                    page_strobe_out <= 1'b1;
                    left_r <= left_r - 2'h1;
                end else
                    print_cmd_out <= 1'b0;
            end
        end
    end
endmodule

// file: verif/print_engine_sequencer_bench.sv
`timescale 1ns/1ps
module print_engine_sequencer_bench;
    typedef struct {logic wr; logic [3:0] a; logic [31:0] d; logic [31:0] e;} row_t;
    // Register rows: reset values, read-back and an unmapped hole
    row_t rows [8] = '{'{1'h0, 4'h0, 32'h0, 32'h1}, '{1'h0, 4'h8, 32'h0, 32'h80}, '{1'h1, 4'h8, 32'h5a, 32'h0},
        '{1'h0, 4'h8, 32'h0, 32'h5a}, '{1'h1, 4'h2, 32'hff, 32'h0}, '{1'h0, 4'h2, 32'h0, 32'h0},
        '{1'h0, 4'hc, 32'h0, 32'h0}, '{1'h0, 4'h4, 32'h0, 32'h0}};
    logic        clock_in = 1'b0;
    logic        arst_n_in = 1'b0;
    logic        avs_read_in = 1'b0;
    logic        avs_write_in = 1'b0;
    logic [3:0]  avs_address_in = 4'h0;
    logic [3:0]  avs_byteenable_in = 4'hf;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [31:0] q;
    logic [10:0] wv = 11'h3f0;
    logic [3:0]  sv = 4'h0;
    logic        failure_in = 1'b0;
    logic        motors_stopped_in = 1'b0;
    logic        job = 1'b0;
    int          miscompares = 0;
    int          n_compared = 0;
    int          cyc = 0, pulses = 0;
    wire         temps_ready_in, cart_present_in, toner_read_done_in, cassette_ok_in, jam_in, wrap_jam_in;
    wire         door_open_in, sleep_in, reserve_cmd_in, print_cmd_in, fmt_to_eng_in;
    wire         scanner_ready_in, hv_present_in, scanner_at_speed_in, pickup_done_in;
    wire [2:0]   accessory_ack_in, phase_out, accessory_open_out;
    wire [31:0]  avs_readdata_out;
    wire [7:0]   fuser_target_out, press_target_out, speed_out;
    wire [5:0]   fan_on_out;
    wire         avs_waitrequest_out, fan_half_out, fan_duplex_out, heater_on_out, fmt_link_en_out, cart_check_out;
    wire         toner_read_out, fuser_motor_out, drum_motor_out, scanner_motor_out, bias_charge_out, bias_develop_out;
    wire         bias_transfer_out, transfer_neg_out, pickup_start_out, eng_to_fmt_out, next_pickup_out, cart_write_out;
    // Warm-up condition inputs and spin-up readiness inputs
    assign {temps_ready_in, cart_present_in, toner_read_done_in, accessory_ack_in, cassette_ok_in, jam_in, wrap_jam_in,
            door_open_in, sleep_in} = wv;
    assign {scanner_ready_in, hv_present_in, scanner_at_speed_in, pickup_done_in} = sv;
    print_engine_sequencer #(.TICK_CYCLES(4)) u_dut (.*);
    formatter_model u_fmt (.clock_in(clock_in), .arst_n_in(arst_n_in), .job_in(job), .phase_in(phase_out),
        .reserve_cmd_out(reserve_cmd_in), .print_cmd_out(print_cmd_in), .page_strobe_out(fmt_to_eng_in));
    // Clock, cycle count since release, next-pickup watch
    always #20 clock_in = ~clock_in;
    always @(posedge clock_in) begin
        cyc <= arst_n_in ? cyc + 1 : 0;
        if (next_pickup_out === 1'b1) begin
            pulses++;
            chk("speed", speed_out, 32'h5a);
        end
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] rd);
        int n = 0;
        @(posedge clock_in);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_write_in <= wr;
        avs_read_in <= !wr;
        do begin
            @(posedge clock_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 20);
        rd = avs_readdata_out;
        chk("bus answer", n < 20, 32'h1);
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
    endtask
    task automatic waitph(input logic [2:0] p);
        int n = 0;
        while (phase_out !== p && n < 400) begin
            @(posedge clock_in);
            n++;
        end
        chk("phase", phase_out, p);
    endtask
    task automatic waitcyc(input int c);
        while (cyc < c) @(posedge clock_in);
    endtask
    task automatic stop_test;
        if (miscompares == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Watchdog far beyond the expected run
    initial begin
        #(40 * 60000);
        miscompares++;
        stop_test();
    end
    // Main sequence
    initial begin
        repeat (4) @(posedge clock_in);
        chk("reset values", {phase_out, avs_waitrequest_out, fuser_target_out, press_target_out, speed_out}, 28'h1b48c80);
        arst_n_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        chk("warm drive", {fan_on_out, fan_duplex_out, heater_on_out, fmt_link_en_out, accessory_open_out}, 32'hfff);
        foreach (rows[i]) begin
            bus(rows[i].wr, rows[i].a, rows[i].d, q);
            if (!rows[i].wr)
                chk("register", q, rows[i].e);
        end
        waitcyc(1150);
        chk("duplex on", fan_duplex_out, 32'h1);
        waitcyc(1260);
        chk("duplex off", fan_duplex_out, 32'h0);
        waitcyc(11950);
        chk("fans on", fan_on_out, 32'h3f);
        waitcyc(12060);
        chk("fans off", {phase_out, fan_on_out}, 32'h0);
        for (int i = 0; i < 10; i++) begin
            wv <= 11'h7f0 ^ (11'h1 << i);
            repeat (12) @(posedge clock_in);
            chk("warm hold", {phase_out, cart_check_out, toner_read_out}, {30'h0, i == 9, i == 8});
        end
        wv <= 11'h7f0;
        waitph(3'd1);
        chk("idle", {fan_on_out, fan_half_out, fuser_target_out, press_target_out}, 32'h3fb48c);
        bus(1'b1, 4'h0, 32'h0, q);
        job <= 1'b1;
        repeat (20) @(posedge clock_in);
        chk("run off", phase_out, 32'h1);
        bus(1'b1, 4'h0, 32'h3, q);
        waitph(3'd2);
        job <= 1'b0;
        chk("spin targets", {fan_on_out, fan_half_out, fuser_target_out, press_target_out}, 32'h7ebeb4);
        chk("spin drive", {scanner_motor_out, fuser_motor_out, drum_motor_out, transfer_neg_out, bias_charge_out,
            bias_develop_out, bias_transfer_out, pickup_start_out}, 32'hff);
        repeat (30) @(posedge clock_in);
        chk("spin hold", phase_out, 32'h2);
        sv <= 4'hf;
        waitph(3'd3);
        chk("engine signal", eng_to_fmt_out, 32'h1);
        waitph(3'd4);
        chk("pickups", pulses, 32'h2);
        chk("down", {fuser_motor_out, drum_motor_out, scanner_motor_out, cart_write_out, fan_on_out, fuser_target_out},
            32'h7fb4);
        bus(1'b0, 4'hc, 32'h0, q);
        chk("pages", q, 32'h2);
        motors_stopped_in <= 1'b1;
        waitph(3'd1);
        motors_stopped_in <= 1'b0;
        sv <= 4'h0;
        job <= 1'b1;
        waitph(3'd2);
        job <= 1'b0;
        failure_in <= 1'b1;
        waitph(3'd4);
        bus(1'b0, 4'h4, 32'h0, q);
        chk("failure flag", q[6], 32'h1);
        failure_in <= 1'b0;
        motors_stopped_in <= 1'b1;
        waitph(3'd1);
        stop_test();
    end
endmodule
